//--- hw/psram_access_and_refresh.sv
`timescale 1ns/1ps
`include "psram_ctrl_defines.svh"
// Overview of operation
// - write spans select and write-strobe overlap
// - host drives data only while writing
// - wait 100 us, then eight dummy cycles
// - refresh within 15 us after self refresh
// - hold both strobes high 600 ns after self
// - no refresh pulse inside reset interval
// - 2048 refreshes every 32 ms
// - auto refresh pulse 70 ns to 8 us
// - wait 5 ms after retention recovery
// - raise shared strobe before refresh pulse
module psram_access_and_refresh
    import psram_ctrl_pkg::*;
#(
    parameter int POWERUP_CYC  = `POWERUP_WAIT_CYC,
    parameter int RECOVERY_CYC = `RECOVERY_CYC,
    parameter int SELF_CYC     = `SELF_PULSE_CYC
)(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        req_valid,
    input  wire mem_req_t    req,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [7:0]       rsp_rdata,
    input  wire logic        self_refresh_req,
    input  wire logic        retention_exit,
    output logic             mem_ready,
    output logic             chip_select_n,
    output logic             output_enable_refresh_n,
    output logic             write_enable_n,
    output logic [18:0]      word_address,
    output logic [7:0]       data_lines_out,
    output logic             data_lines_oe,
    input  wire logic [7:0]  data_lines_in
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ctrl_state_t          state_reg, state_next;
    logic [`TIMER_W-1:0]  cnt_reg, cnt_next;
    logic [`TIMER_W-1:0]  rint_reg;
    logic [3:0]           init_reg;
    logic                 rpend_reg;
    logic                 self_exit_reg;
    logic                 rsp_valid_reg;
    logic [7:0]           rdata_reg;
    strobe_t              pins_reg, pins_next;
    logic [18:0]          addr_reg;
    logic [7:0]           wdata_reg;
    logic                 oe_reg;
    logic                 ready_reg;
    logic                 mready_reg;
    logic [2:0]           sr_sync_reg, rx_sync_reg;
    logic                 sr_level_reg, rx_level_reg;
    logic                 rx_pend_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire cnt_done    = (cnt_reg == '0);
    wire tick        = (rint_reg == '0);
    // a pin level counts once the last two stages agree
    wire sr_agree    = (sr_sync_reg[2] == sr_sync_reg[1]);
    wire rx_agree    = (rx_sync_reg[2] == rx_sync_reg[1]);
    wire self_req    = sr_level_reg;
    wire rx_rise     = rx_agree & rx_sync_reg[2] & ~rx_level_reg;
    wire rx_now      = rx_pend_reg;
    // ready is only granted when the next edge will take the request
    wire take        = (state_reg == ST_IDLE) & ready_reg & req_valid;
    wire go_refresh  = (state_reg == ST_IDLE) & (rpend_reg | self_exit_reg) & ~(take);
    wire in_init     = (init_reg != 4'h0);
    wire refresh_clr = (state_reg == ST_IDLE) & (state_next == ST_AUTO);
    // a new tick wins over the clear
    wire rpend_d     = tick | (rpend_reg & ~refresh_clr);
    wire sexit_d     = (state_reg == ST_RESETGAP) | (self_exit_reg & ~refresh_clr);
    wire rx_pend_d   = rx_rise | (rx_pend_reg & ~((state_reg == ST_IDLE) & (state_next == ST_POWERUP)));

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_done ? cnt_reg : cnt_reg - `TIMER_W'(1);
        pins_next  = pins_reg;
        case (state_reg)
            ST_POWERUP: begin
                if (cnt_done) begin
                    state_next = ST_INIT;
                    cnt_next   = `TIMER_W'(`AUTO_PULSE_CYC);
                    pins_next  = '{1'b1, 1'b0, 1'b1};
                end
            end
            ST_INIT: begin
                if (cnt_done) begin
                    state_next = ST_PRECHG;
                    cnt_next   = `TIMER_W'(`PRECHARGE_CYC);
                    pins_next  = '{1'b1, 1'b1, 1'b1};
                end
            end
            ST_IDLE: begin
                if (take) begin
                    state_next = req.write ? ST_WRITE : ST_READ;
                    cnt_next   = `TIMER_W'(`ACCESS_CYC);
                    // select and write strobe fall together: memory stays high-z
                    pins_next  = req.write ? strobe_t'{1'b0, 1'b1, 1'b0}
                                           : strobe_t'{1'b0, 1'b0, 1'b1};
                end else if (rx_now) begin
                    state_next = ST_POWERUP;
                    cnt_next   = `TIMER_W'(RECOVERY_CYC);
                end else if (self_req) begin
                    state_next = ST_SELF;
                    cnt_next   = `TIMER_W'(SELF_CYC);
                    pins_next  = '{1'b1, 1'b0, 1'b1};
                end else if (go_refresh) begin
                    state_next = ST_AUTO;
                    cnt_next   = `TIMER_W'(`AUTO_PULSE_CYC);
                    pins_next  = '{1'b1, 1'b0, 1'b1};
                end
            end
            ST_READ, ST_WRITE: begin
                if (cnt_done) begin
                    // select and strobes rise together so no refresh starts
                    state_next = ST_PRECHG;
                    cnt_next   = `TIMER_W'(`PRECHARGE_CYC);
                    pins_next  = '{1'b1, 1'b1, 1'b1};
                end
            end
            ST_AUTO: begin
                if (cnt_done) begin
                    state_next = ST_PRECHG;
                    cnt_next   = `TIMER_W'(`PRECHARGE_CYC);
                    pins_next  = '{1'b1, 1'b1, 1'b1};
                end
            end
            ST_SELF: begin
                if (cnt_done & ~self_req) begin
                    state_next = ST_RESETGAP;
                    cnt_next   = `TIMER_W'(`REFRESH_RESET_CYC);
                    pins_next  = '{1'b1, 1'b1, 1'b1};
                end
            end
            ST_RESETGAP: begin
                if (cnt_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_PRECHG: begin
                if (cnt_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                pins_next  = '{1'b1, 1'b1, 1'b1};
            end
        endcase
        if (state_reg == ST_PRECHG && cnt_done && in_init) begin
            state_next = ST_INIT;
            cnt_next   = `TIMER_W'(`AUTO_PULSE_CYC);
            pins_next  = '{1'b1, 1'b0, 1'b1};
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_POWERUP;
            cnt_reg   <= `TIMER_W'(POWERUP_CYC);
            pins_reg  <= '{1'b1, 1'b1, 1'b1};
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            pins_reg  <= pins_next;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sr_sync_reg  <= 3'h0;
            rx_sync_reg  <= 3'h0;
            sr_level_reg <= 1'b0;
            rx_level_reg <= 1'b0;
            rx_pend_reg  <= 1'b0;
        end else begin
            sr_sync_reg  <= {sr_sync_reg[1:0], self_refresh_req};
            rx_sync_reg  <= {rx_sync_reg[1:0], retention_exit};
            sr_level_reg <= sr_agree ? sr_sync_reg[2] : sr_level_reg;
            rx_level_reg <= rx_agree ? rx_sync_reg[2] : rx_level_reg;
            rx_pend_reg  <= rx_pend_d;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            init_reg <= 4'h0;
        end else if (state_reg == ST_POWERUP && cnt_done) begin
            init_reg <= 4'(`INIT_CYCLES);
        end else if (state_reg == ST_INIT && cnt_done) begin
            init_reg <= init_reg - 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rint_reg <= `TIMER_W'(`REFRESH_INTERVAL_CYC - 1);
        end else if (state_reg == ST_SELF) begin
            rint_reg <= `TIMER_W'(`REFRESH_INTERVAL_CYC - 1);
        end else begin
            rint_reg <= tick ? `TIMER_W'(`REFRESH_INTERVAL_CYC - 1) : rint_reg - `TIMER_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rpend_reg     <= 1'b0;
            self_exit_reg <= 1'b0;
        end else begin
            rpend_reg     <= rpend_d;
            self_exit_reg <= sexit_d;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            addr_reg  <= 19'h0;
            wdata_reg <= 8'h0;
            oe_reg    <= 1'b0;
        end else begin
            if (take) begin
                addr_reg  <= req.addr;
                wdata_reg <= req.wdata;
            end
            oe_reg <= (state_next == ST_WRITE);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rsp_valid_reg <= 1'b0;
            rdata_reg     <= 8'h0;
            ready_reg     <= 1'b0;
            mready_reg    <= 1'b0;
        end else begin
            rsp_valid_reg <= (state_reg == ST_READ) & cnt_done;
            if ((state_reg == ST_READ) & cnt_done) begin
                rdata_reg <= data_lines_in;
            end
            ready_reg  <= (state_next == ST_IDLE) & ~in_init & ~rpend_d & ~sexit_d & ~rx_pend_d & ~self_req;
            mready_reg <= ~in_init & (state_next != ST_POWERUP) & (state_next != ST_INIT);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign req_ready               = ready_reg;
    assign rsp_valid               = rsp_valid_reg;
    assign rsp_rdata               = rdata_reg;
    assign mem_ready               = mready_reg;
    assign chip_select_n           = pins_reg.chip_select_n;
    assign output_enable_refresh_n = pins_reg.output_enable_refresh_n;
    assign write_enable_n          = pins_reg.write_enable_n;
    assign word_address            = addr_reg;
    assign data_lines_out          = wdata_reg;
    assign data_lines_oe           = oe_reg;

endmodule

//--- hw/psram_ctrl_defines.svh
`ifndef PSRAM_CTRL_DEFINES_SVH
`define PSRAM_CTRL_DEFINES_SVH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS          50
`define POWERUP_WAIT_US        100
`define POWERUP_WAIT_CYC       ((`POWERUP_WAIT_US * 1000) / `CLK_PERIOD_NS + 1)
`define INIT_CYCLES            8
`define REFRESH_PERIOD_MS      32
`define REFRESH_ROWS           2048
`define REFRESH_INTERVAL_CYC   ((`REFRESH_PERIOD_MS * 1000000) / `CLK_PERIOD_NS / `REFRESH_ROWS)
`define AUTO_PULSE_MIN_NS      70
`define AUTO_PULSE_CYC         ((`AUTO_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELF_PULSE_US          8
`define SELF_PULSE_CYC         ((`SELF_PULSE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define REFRESH_RESET_NS       600
`define REFRESH_RESET_CYC      ((`REFRESH_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define SELF_EXIT_US           15
`define SELF_EXIT_CYC          ((`SELF_EXIT_US * 1000) / `CLK_PERIOD_NS)
`define RECOVERY_MS            5
`define RECOVERY_CYC           ((`RECOVERY_MS * 1000000) / `CLK_PERIOD_NS)
`define ACCESS_CYC             2
`define PRECHARGE_CYC          1
`define TIMER_W                17

`endif

//--- hw/psram_ctrl_pkg.sv
package psram_ctrl_pkg;

    typedef struct packed {
        logic        write;
        logic [18:0] addr;
        logic [7:0]  wdata;
    } mem_req_t;

    typedef struct packed {
        logic       chip_select_n;
        logic       output_enable_refresh_n;
        logic       write_enable_n;
    } strobe_t;

    typedef enum logic [8:0] {
        ST_POWERUP  = 9'h001,
        ST_INIT     = 9'h002,
        ST_IDLE     = 9'h004,
        ST_READ     = 9'h008,
        ST_WRITE    = 9'h010,
        ST_PRECHG   = 9'h020,
        ST_AUTO     = 9'h040,
        ST_SELF     = 9'h080,
        ST_RESETGAP = 9'h100
    } ctrl_state_t;

endpackage

//--- sim/psram_access_and_refresh_sva.sv
`timescale 1ns/1ps
module psram_access_and_refresh_sva
    import psram_ctrl_pkg::*;
#(
    parameter int POWERUP_CYC = 20,
    parameter int SELF_CYC    = 161
)(
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic       req_ready,
    input wire logic       rsp_valid,
    input wire logic       retention_exit,
    input wire logic       mem_ready,
    input wire logic       chip_select_n,
    input wire logic       output_enable_refresh_n,
    input wire logic       write_enable_n,
    input wire logic       data_lines_oe,
    input wire logic [7:0] data_lines_out
);
    // ----------------------------------------
    // pin timing checks
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    int cyc_cnt;
    int hi_cnt;
    int lo_cnt;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cyc_cnt <= 0;
            hi_cnt  <= 0;
            lo_cnt  <= 0;
        end else begin
            cyc_cnt <= (cyc_cnt < 100000) ? cyc_cnt + 1 : cyc_cnt;
            hi_cnt  <= output_enable_refresh_n ? hi_cnt + 1 : 0;
            lo_cnt  <= output_enable_refresh_n ? 0 : lo_cnt + 1;
        end
    end
    a_no_contention: assert property (data_lines_oe |-> output_enable_refresh_n && !write_enable_n)
        else $error("host drives data lines outside a write");
    a_write_window: assert property ($fell(write_enable_n) |-> !chip_select_n ##1
        (!write_enable_n && $stable(data_lines_out))[*2] ##1 write_enable_n) else $error("bad write window");
    a_read_answer: assert property ($fell(chip_select_n) && !output_enable_refresh_n |->
        !chip_select_n[*3] ##1 (chip_select_n && rsp_valid)) else $error("read answer late");
    a_auto_width: assert property ($fell(output_enable_refresh_n) && chip_select_n |->
        !output_enable_refresh_n[*2]) else $error("refresh pulse too short");
    a_strobe_rearm: assert property ($rose(chip_select_n) |-> output_enable_refresh_n)
        else $error("strobe low at access end");
    a_refresh_gap: assert property (mem_ready |-> hi_cnt < 340)
        else $error("refresh interval exceeded");
    a_powerup_wait: assert property ($fell(output_enable_refresh_n) |-> cyc_cnt >= POWERUP_CYC)
        else $error("init pulse before power-up wait");
    a_exit_quiet: assert property ($rose(output_enable_refresh_n) && lo_cnt >= SELF_CYC |->
        (chip_select_n && output_enable_refresh_n)[*8] ##1 (chip_select_n && output_enable_refresh_n)[*4])
        else $error("strobes not quiet after self refresh");
    a_exit_refresh: assert property ($rose(output_enable_refresh_n) && lo_cnt >= SELF_CYC |->
        ##[1:300] ($fell(output_enable_refresh_n) && chip_select_n)) else $error("no refresh after self refresh");
    a_recovery_hold: assert property ($rose(retention_exit) |-> ##5 (!mem_ready && !req_ready)[*8])
        else $error("access allowed during recovery");
    a_ready_idle: assert property (req_ready |-> chip_select_n && output_enable_refresh_n)
        else $error("ready while pins busy");
endmodule
bind psram_access_and_refresh psram_access_and_refresh_sva #(.POWERUP_CYC(POWERUP_CYC), .SELF_CYC(SELF_CYC)) i_sva (.*);

//--- sim/psram_model.sv
`timescale 1ns/1ps
module psram_model (
    input  wire logic        chip_select_n,
    input  wire logic        output_enable_refresh_n,
    input  wire logic        write_enable_n,
    input  wire logic [18:0] word_address,
    input  wire logic [7:0]  data_lines,
    output logic      [7:0]  dq_out,
    output int               auto_cnt,
    output int               self_cnt,
    output int               bad_cnt
);
    // ----------------------------------------
    // behavioural memory
    // ----------------------------------------
    logic [7:0]  mem [0:524287];
    logic [18:0] addr_q  = '0;
    logic        no_out  = 1'b1;
    logic        writing = 1'b0;
    logic        armed   = 1'b0;
    realtime     t_low   = 0;
    realtime     t_exit  = -1.0e6;
    wire         drive   = !chip_select_n && !output_enable_refresh_n && write_enable_n && !no_out;
    // released lines show the inverse of the last value
    assign dq_out = drive ? mem[addr_q] : ~mem[addr_q];
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        auto_cnt = 0;
        self_cnt = 0;
        bad_cnt  = 0;
    end
    always @(negedge chip_select_n) begin
        if ($realtime - t_exit < 600) bad_cnt++;
        #1;
        addr_q = word_address;
        no_out = !write_enable_n;
    end
    always @(chip_select_n or write_enable_n) begin
        if (!chip_select_n && !write_enable_n) writing = 1'b1;
        else if (writing) begin
            mem[addr_q] = data_lines;
            writing = 1'b0;
        end
    end
    always @(negedge output_enable_refresh_n) begin
        t_low = $realtime;
        if ($realtime - t_exit < 600) bad_cnt++;
        // select may change in the same step as the strobe
        #1;
        armed = chip_select_n;
    end
    always @(posedge output_enable_refresh_n) begin
        if (armed && $realtime - t_low >= 8000) begin
            self_cnt++;
            t_exit = $realtime;
        end else if (armed && $realtime - t_low >= 70) auto_cnt++;
        else if (armed) bad_cnt++;
        armed = 1'b0;
    end
endmodule

//--- sim/test_psram_access_and_refresh.sv
`timescale 1ns/1ps
module test_psram_access_and_refresh
    import psram_ctrl_pkg::*;
;
`define CHK(name, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("MISMATCH %s expected %0h seen %0h", name, exp, got); end end
    // ----------------------------------------
    // bench
    // ----------------------------------------
    logic        ref_clk = 0, resetn = 0, req_valid = 0, self_refresh_req = 0, retention_exit = 0;
    mem_req_t    req = '0;
    logic        req_ready, rsp_valid, mem_ready, cs_n, oe_n, we_n, data_lines_oe;
    logic [7:0]  rsp_rdata, data_lines_out, m_out;
    logic [18:0] word_address;
    wire  [7:0]  bus;
    int          errors = 0, checks = 0, cycles = 0, auto_cnt, self_cnt, bad_cnt, a0;
    assign #1 bus = data_lines_oe ? data_lines_out : m_out;
    psram_access_and_refresh #(.POWERUP_CYC(20), .RECOVERY_CYC(30), .SELF_CYC(161)) i_psram_access_and_refresh (
        .ref_clk(ref_clk), .resetn(resetn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .self_refresh_req(self_refresh_req),
        .retention_exit(retention_exit), .mem_ready(mem_ready), .chip_select_n(cs_n),
        .output_enable_refresh_n(oe_n), .write_enable_n(we_n), .word_address(word_address),
        .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .data_lines_in(bus));
    psram_model i_psram_model (.chip_select_n(cs_n), .output_enable_refresh_n(oe_n), .write_enable_n(we_n),
        .word_address(word_address), .data_lines(bus), .dq_out(m_out), .auto_cnt(auto_cnt),
        .self_cnt(self_cnt), .bad_cnt(bad_cnt));
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_ready();
        int n = 0;
        while (mem_ready !== 1'b1 && n < 1000) begin @(posedge ref_clk); n++; end
        @(negedge ref_clk);
    endtask
    task automatic access(input logic wr, input logic [18:0] a, input logic [7:0] d);
        int n = 0;
        @(negedge ref_clk);
        req = '{write: wr, addr: a, wdata: d};
        req_valid = 1'b1;
        do begin @(posedge ref_clk); n++; end while (req_ready !== 1'b1 && n < 2000);
        @(negedge ref_clk);
        req_valid = 1'b0;
        n = 0;
        while (!wr && rsp_valid !== 1'b1 && n < 20) begin @(posedge ref_clk); #1; n++; end
        if (!wr) `CHK("read data", d, rsp_rdata)
    endtask
    task automatic t_access();
        logic [18:0] addrs [3] = '{19'h00000, 19'h7ffff, 19'h007ff};
        foreach (addrs[i]) access(1'b1, addrs[i], 8'h5a ^ 8'(i));
        foreach (addrs[i]) access(1'b0, addrs[i], 8'h5a ^ 8'(i));
    endtask
    task automatic t_refresh_load();
        int c0 = cycles;
        a0 = auto_cnt;
        repeat (80) access(1'b0, 19'h7ffff, 8'h5b);
        repeat (200) @(posedge ref_clk);
        `CHK("refresh count", 1'b1, auto_cnt - a0 >= (cycles - c0) / 312)
    endtask
    task automatic t_self();
        a0 = auto_cnt;
        @(negedge ref_clk);
        self_refresh_req = 1'b1;
        repeat (200) @(negedge ref_clk);
        self_refresh_req = 1'b0;
        repeat (330) @(negedge ref_clk);
        `CHK("self refresh", 1, self_cnt)
        `CHK("refresh after exit", 1'b1, auto_cnt > a0)
        access(1'b0, 19'h007ff, 8'h58);
    endtask
    task automatic t_retention();
        // start just after a refresh pulse so the block is idle
        while (!(cs_n && !oe_n)) @(negedge ref_clk);
        while (!oe_n) @(negedge ref_clk);
        repeat (3) @(negedge ref_clk);
        a0 = auto_cnt;
        retention_exit = 1'b1;
        repeat (2) @(negedge ref_clk);
        retention_exit = 1'b0;
        repeat (8) @(negedge ref_clk);
        `CHK("recovery ready", 1'b0, mem_ready)
        wait_ready();
        `CHK("reinit pulses", 1'b1, auto_cnt - a0 >= 8)
        access(1'b0, 19'h00000, 8'h5a);
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        wait_ready();
        `CHK("init pulses", 8, auto_cnt)
        t_access();
        t_refresh_load();
        t_self();
        t_retention();
        `CHK("model faults", 0, bad_cnt)
        give_verdict();
    end
endmodule
